// ==== design/iec_edge_det.sv ====
// Selectable edge detector for the external request pins.
`timescale 1ns/100ps
`default_nettype none
module iec_edge_det #(
  parameter int W = 5
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins, edge choice and pin function.
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] rising_sel,
  input  wire logic [W-1:0] arm,
  // One-cycle detection pulses.
  output logic      [W-1:0] pulse
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic         valid;
  } iec_edge_t;

  iec_edge_t st_reg;
  iec_edge_t st_next;

  // Remembers the last pin level; no edge is seen in the first cycle after reset.
  always_comb
  begin
    st_next       = st_reg;
    st_next.prev  = pin;
    st_next.valid = 1'b1;
  end

  // Registers the detector state.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Picks the rising or the falling edge per pin, only for pins used as request inputs.
  assign pulse = {W{st_reg.valid}} & arm &
                 ((rising_sel & ~st_reg.prev & pin) | (~rising_sel & st_reg.prev & ~pin));

endmodule
`default_nettype wire

// ==== design/iec_flag_bank.sv ====
// Bank of sticky flags that hardware sets and a write clears.
`timescale 1ns/100ps
`default_nettype none
module iec_flag_bank #(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Set events and clear requests.
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Flag values.
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] flags;
  } iec_bank_t;

  iec_bank_t st_reg;
  iec_bank_t st_next;

  // A set arriving in the same cycle as its clear wins.
  always_comb
  begin
    st_next       = st_reg;
    st_next.flags = (st_reg.flags & ~clr) | set;
  end

  // Registers the flags.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.flags;

endmodule
`default_nettype wire

// ==== design/iec_pkg.sv ====
// Package with the register map, field layout and reset values of the interrupt control registers.
package iec_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_EDGE_POLARITY_SELECT = 16'hfff2;
  localparam logic [15:0] IDX_SOURCE_ENABLE_LOW    = 16'hfff3;
  localparam logic [15:0] IDX_SOURCE_ENABLE_HIGH   = 16'hfff4;
  localparam logic [15:0] IDX_PENDING_FLAGS_LOW    = 16'hfff6;
  localparam logic [15:0] IDX_PENDING_FLAGS_HIGH   = 16'hfff7;
  localparam logic [15:0] IDX_WAKEUP_PENDING_FLAGS = 16'hfff9;
  localparam logic [15:0] IDX_IRQ_STATUS           = 16'hfffa;
  localparam logic [15:0] IDX_IRQ_CLEAR            = 16'hfffb;
  localparam logic [15:0] IDX_IRQ_ENABLE           = 16'hfffc;

  // ----------------------------------------------------------------
  // Widths, reset values and field positions
  // ----------------------------------------------------------------
  localparam int          ADDR_W             = 18;
  localparam int          EXT_PINS           = 5;
  localparam int          WAKE_PINS          = 8;
  localparam int          STAT_W             = 3;
  localparam logic [7:0]  RST_EDGE_SELECT    = 8'he0;
  localparam logic [2:0]  EDGE_RSVD_BITS     = 3'h7;
  localparam logic [7:0]  RST_ENABLE         = 8'h00;
  localparam logic [7:0]  RST_PENDING_LOW    = 8'h20;
  localparam logic [7:0]  RST_PENDING_HIGH   = 8'h00;
  localparam logic [7:0]  RST_WAKEUP_PENDING = 8'h00;
  localparam logic [2:0]  RST_IRQ_STATUS     = 3'h0;
  localparam int          POS_TIMER_A        = 7;
  localparam int          POS_SERIAL1        = 6;
  localparam int          POS_WAKEUP_GROUP   = 5;
  localparam int          POS_STAT_EXT       = 0;
  localparam int          POS_STAT_PERIPH    = 1;
  localparam int          POS_STAT_WAKE      = 2;

  // ----------------------------------------------------------------
  // Control state of the register block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  edge_sel;
    logic [7:0]  en_low;
    logic [7:0]  en_high;
    logic [2:0]  irq_en;
    logic [31:0] rdata;
    logic        slverr;
  } iec_ctrl_t;

endpackage

// ==== design/iec_regs.sv ====
// Interrupt edge select, enable and request flag registers behind an APB slave.
// Function
// - edge select resets e0, top bits read 1
// - edge bit 0 falling, 1 rising
// - enable low bits 7,6 gate timer A, serial1
// - enable low bit 5 gates all wakeup pins
// - enable low bits 4..0 gate pin requests
// - enable high bits 7,6 gate transfer, converter
// - enable high bits 5,4 gate serial2, timer G
// - enable high bits 3,2 gate timer FH, FL
// - enable high bits 1,0 gate timers C, B
// - pending low flags set by events, reset 20
// - flags stay set until software writes 0
// - writing 0 clears a flag, 1 keeps
// - global mask blocks acceptance, flags still set
// - pending low bit 5 reads 1 always
// - pin flag needs request mode and edge
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module iec_regs (
  // Clock and reset.
  input  wire logic                          SYS_CLK,
  input  wire logic                          RESET_N,
  // APB slave.
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [iec_pkg::ADDR_W-1:0]    PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // External request pins and their pin function.
  input  wire logic [iec_pkg::EXT_PINS-1:0]  EXT_PIN,
  input  wire logic [iec_pkg::EXT_PINS-1:0]  EXT_PIN_IRQ_MODE,
  // Peripheral events, one-cycle pulses.
  input  wire logic                          EVT_TIMER_A,
  input  wire logic                          EVT_SERIAL1,
  input  wire logic [7:0]                    EVT_HIGH,
  input  wire logic [iec_pkg::WAKE_PINS-1:0] WAKEUP_EVT,
  // CPU exception logic.
  input  wire logic                          CPU_INT_MASK,
  output logic      [7:0]                    REQ_LOW,
  output logic      [7:0]                    REQ_HIGH,
  output logic                               INT_REQ,
  // Block interrupt.
  output logic                               IRQ_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  iec_pkg::iec_ctrl_t st_reg;
  iec_pkg::iec_ctrl_t st_next;

  logic [15:0]                   acc_idx;
  logic                          wr_acc;
  logic                          setup_rd;
  logic [iec_pkg::EXT_PINS-1:0]  pin_pulse;
  logic [6:0]                    pend_low_set;
  logic [6:0]                    pend_low_clr;
  logic [6:0]                    pend_low;
  logic [7:0]                    pend_high_clr;
  logic [7:0]                    pend_high;
  logic [7:0]                    wake_clr;
  logic [7:0]                    wake_pend;
  logic [2:0]                    stat_set;
  logic [2:0]                    stat_clr;
  logic [2:0]                    stat;
  logic [7:0]                    pend_low_view;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Word index of the access and the strobes of the two bus phases.
  assign acc_idx  = PADDR[iec_pkg::ADDR_W-1:2];
  assign wr_acc   = PSEL & PENABLE & PWRITE;
  assign setup_rd = PSEL & ~PENABLE;
  assign PREADY   = PENABLE;

  // Pending low as seen by software, with the fixed bit in place.
  // fixed one
  assign pend_low_view = {pend_low[6:5], 1'b1, pend_low[4:0]};

  // ----------------------------------------------------------------
  // Edge detection and flag banks
  // ----------------------------------------------------------------
  // Pin edges; the polarity comes from the edge select bits.
  // pin edges
  iec_edge_det #(
    .W          (iec_pkg::EXT_PINS)
  ) u_edge (
    .clk        (SYS_CLK),
    .rst_n      (RESET_N),
    .pin        (EXT_PIN),
    .rising_sel (st_reg.edge_sel),
    .arm        (EXT_PIN_IRQ_MODE),
    .pulse      (pin_pulse)
  );

  // Set and clear vectors; a pending flag write clears only where a data bit is 0, the status clear write where it is 1.
  // set clear
  assign pend_low_set  = {EVT_TIMER_A, EVT_SERIAL1, pin_pulse};
  assign pend_low_clr  = (wr_acc && acc_idx == iec_pkg::IDX_PENDING_FLAGS_LOW) ?
                         ~{PWDATA[7:6], PWDATA[4:0]} : 7'h00;
  assign pend_high_clr = (wr_acc && acc_idx == iec_pkg::IDX_PENDING_FLAGS_HIGH) ? ~PWDATA[7:0] : 8'h00;
  assign wake_clr      = (wr_acc && acc_idx == iec_pkg::IDX_WAKEUP_PENDING_FLAGS) ? ~PWDATA[7:0] : 8'h00;
  assign stat_clr      = (wr_acc && acc_idx == iec_pkg::IDX_IRQ_CLEAR) ? PWDATA[2:0] : 3'h0;

  // Pending low flags: timer A, serial 1 and the five pins.
  // sticky flags
  iec_flag_bank #(
    .W     (7),
    .RST   ({iec_pkg::RST_PENDING_LOW[7:6], iec_pkg::RST_PENDING_LOW[4:0]})
  ) u_pend_low (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .set   (pend_low_set),
    .clr   (pend_low_clr),
    .q     (pend_low)
  );

  // Pending high flags: transfer, converter, serial 2 and the timers.
  iec_flag_bank #(
    .W     (8),
    .RST   (iec_pkg::RST_PENDING_HIGH)
  ) u_pend_high (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .set   (EVT_HIGH),
    .clr   (pend_high_clr),
    .q     (pend_high)
  );

  // Wakeup pending flags, one per wakeup pin.
  iec_flag_bank #(
    .W     (iec_pkg::WAKE_PINS),
    .RST   (iec_pkg::RST_WAKEUP_PENDING)
  ) u_wake (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .set   (WAKEUP_EVT),
    .clr   (wake_clr),
    .q     (wake_pend)
  );

  // Block status: a pin, a peripheral or a wakeup flag was set.
  assign stat_set = {|WAKEUP_EVT, EVT_TIMER_A | EVT_SERIAL1 | (|EVT_HIGH), |pin_pulse};

  iec_flag_bank #(
    .W     (iec_pkg::STAT_W),
    .RST   (iec_pkg::RST_IRQ_STATUS)
  ) u_stat (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .set   (stat_set),
    .clr   (stat_clr),
    .q     (stat)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Writes at the access phase, read data and error captured in the setup phase.
  always_comb
  begin
    st_next = st_reg;
    if (wr_acc)
    begin
      unique case (acc_idx)
        iec_pkg::IDX_EDGE_POLARITY_SELECT: st_next.edge_sel = PWDATA[4:0];
        iec_pkg::IDX_SOURCE_ENABLE_LOW:    st_next.en_low   = PWDATA[7:0];
        iec_pkg::IDX_SOURCE_ENABLE_HIGH:   st_next.en_high  = PWDATA[7:0];
        iec_pkg::IDX_IRQ_ENABLE:           st_next.irq_en   = PWDATA[2:0];
        default:                           st_next.irq_en   = st_reg.irq_en;
      endcase
    end
    if (setup_rd | (PSEL & ~PENABLE))
    begin
      st_next.slverr = 1'b0;
      unique case (acc_idx)
        iec_pkg::IDX_EDGE_POLARITY_SELECT: st_next.rdata = {24'h0, iec_pkg::EDGE_RSVD_BITS, st_reg.edge_sel};
        iec_pkg::IDX_SOURCE_ENABLE_LOW:    st_next.rdata = {24'h0, st_reg.en_low};
        iec_pkg::IDX_SOURCE_ENABLE_HIGH:   st_next.rdata = {24'h0, st_reg.en_high};
        iec_pkg::IDX_PENDING_FLAGS_LOW:    st_next.rdata = {24'h0, pend_low_view};
        iec_pkg::IDX_PENDING_FLAGS_HIGH:   st_next.rdata = {24'h0, pend_high};
        iec_pkg::IDX_WAKEUP_PENDING_FLAGS: st_next.rdata = {24'h0, wake_pend};
        iec_pkg::IDX_IRQ_STATUS:           st_next.rdata = {29'h0, stat};
        iec_pkg::IDX_IRQ_CLEAR:            st_next.rdata = 32'h0;
        iec_pkg::IDX_IRQ_ENABLE:           st_next.rdata = {29'h0, st_reg.irq_en};
        default:
        begin
          st_next.rdata  = 32'h0;
          st_next.slverr = 1'b1;
        end
      endcase
    end
  end

  // Registers the control state.
  // reset values
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_reg          <= '0;
      st_reg.edge_sel <= iec_pkg::RST_EDGE_SELECT[4:0];
      st_reg.en_low   <= iec_pkg::RST_ENABLE;
      st_reg.en_high  <= iec_pkg::RST_ENABLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign PRDATA  = st_reg.rdata;
  assign PSLVERR = st_reg.slverr & PENABLE;

  // ----------------------------------------------------------------
  // Requests to the CPU and block interrupt
  // ----------------------------------------------------------------
  // Each request stands while its flag and its enable are both set.
  // flag and enable
  assign REQ_LOW  = {pend_low[6:5], (|wake_pend) & st_reg.en_low[iec_pkg::POS_WAKEUP_GROUP], pend_low[4:0]} &
                    {st_reg.en_low[7:6], 1'b1, st_reg.en_low[4:0]};
  assign REQ_HIGH = pend_high & st_reg.en_high;

  // The global mask holds acceptance back while flags keep being set.
  // global mask
  assign INT_REQ  = ~CPU_INT_MASK & ((|REQ_LOW) | (|REQ_HIGH));

  // Level interrupt while an enabled status bit is set.
  assign IRQ_OUT  = |(stat & st_reg.irq_en);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Reserved edge bits read as ones.
  chk_edge_rsvd_read: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    PSEL && PENABLE && !PWRITE && acc_idx == iec_pkg::IDX_EDGE_POLARITY_SELECT |-> PRDATA[7:5] == 3'h7)
    else $error("edge select reserved bits not read as one");

  // A falling pin edge with falling selection and request mode sets the flag.
  chk_pin_fall_set: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    $past(RESET_N) && EXT_PIN_IRQ_MODE[1] && !st_reg.edge_sel[1] && $fell(EXT_PIN[1]) |=> pend_low[1])
    else $error("falling pin edge did not set its flag");

  // A pin flag rises only when the pin was in request mode.
  chk_pin_mode_gate: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(pend_low[1]) |-> $past(EXT_PIN_IRQ_MODE[1]) && $past(EXT_PIN[1]) != $past(EXT_PIN[1], 2))
    else $error("pin flag set without request mode or edge");

  // Timer A event sets its flag even while the CPU is masked.
  chk_mask_flag_set: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    EVT_TIMER_A |=> pend_low[6] && (CPU_INT_MASK -> !INT_REQ))
    else $error("masked event not flagged or request accepted");

  // Writing ones leaves the high flags as they were or higher.
  chk_write_one_keeps: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    wr_acc && acc_idx == iec_pkg::IDX_PENDING_FLAGS_HIGH && PWDATA[7:0] == 8'hff |=>
    (pend_high & $past(pend_high)) == $past(pend_high))
    else $error("writing one changed a pending flag");

  // A set in the cycle of a clearing write wins.
  chk_set_over_clear: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    pend_high_clr[0] && EVT_HIGH[0] |=> pend_high[0])
    else $error("event lost against a clearing write");

  // The fixed pending low bit always reads one.
  chk_rsvd_flag_read: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    PSEL && PENABLE && !PWRITE && acc_idx == iec_pkg::IDX_PENDING_FLAGS_LOW |-> PRDATA[5])
    else $error("reserved pending bit not read as one");

  // Clearing an enable withdraws the request on the next cycle.
  chk_enable_gates: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    wr_acc && acc_idx == iec_pkg::IDX_SOURCE_ENABLE_HIGH && !PWDATA[0] |=> !REQ_HIGH[0])
    else $error("request stands with enable cleared");

  // Timer A request follows its enable bit.
  chk_timer_a_enable: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    pend_low[6] && st_reg.en_low[iec_pkg::POS_TIMER_A] |-> REQ_LOW[7])
    else $error("timer A request missing");

  // An enabled timer A event raises its request one cycle later.
  chk_ta_req_path: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    EVT_TIMER_A && st_reg.en_low[iec_pkg::POS_TIMER_A] && !(wr_acc && acc_idx == iec_pkg::IDX_SOURCE_ENABLE_LOW)
    |=> REQ_LOW[7])
    else $error("enabled timer A event gave no request");

  // A set flag holds while no clearing write hits it.
  chk_flag_sticky: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    pend_high[3] && !pend_high_clr[3] |=> pend_high[3])
    else $error("pending flag dropped without a clear");

  // Writing 0 to a flag with no event in that cycle clears it.
  chk_zero_clears: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    wr_acc && acc_idx == iec_pkg::IDX_PENDING_FLAGS_HIGH && !PWDATA[2] && !EVT_HIGH[2] |=> !pend_high[2])
    else $error("writing zero did not clear the flag");

  // A rising pin edge with rising selection and request mode sets the flag.
  chk_pin_rise_set: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    $past(RESET_N) && EXT_PIN_IRQ_MODE[1] && st_reg.edge_sel[1] && $rose(EXT_PIN[1]) |=> pend_low[1])
    else $error("rising pin edge did not set its flag");

  // A pin outside request mode never raises its flag.
  chk_pin_unarmed: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    !EXT_PIN_IRQ_MODE[0] && !pend_low[0] |=> !pend_low[0])
    else $error("pin flag set outside request mode");

  // Clearing a pin enable withdraws that pin's request.
  chk_pin_en_gate: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    wr_acc && acc_idx == iec_pkg::IDX_SOURCE_ENABLE_LOW && !PWDATA[1] |=> !REQ_LOW[1])
    else $error("pin request stands with enable cleared");

  // Clearing the wakeup group enable withdraws the group request.
  chk_wake_en_gate: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    wr_acc && acc_idx == iec_pkg::IDX_SOURCE_ENABLE_LOW && !PWDATA[iec_pkg::POS_WAKEUP_GROUP] |=> !REQ_LOW[5])
    else $error("wakeup request stands with enable cleared");

  // Main scenarios.
  cov_pin_edge:  cover property (@(posedge SYS_CLK) disable iff (!RESET_N) |pin_pulse);
  cov_clear:     cover property (@(posedge SYS_CLK) disable iff (!RESET_N) |pend_high_clr ##1 !(|pend_high));
  cov_int_req:   cover property (@(posedge SYS_CLK) disable iff (!RESET_N) INT_REQ);
  cov_irq_out:   cover property (@(posedge SYS_CLK) disable iff (!RESET_N) IRQ_OUT);
  cov_masked:    cover property (@(posedge SYS_CLK) disable iff (!RESET_N) CPU_INT_MASK && (|REQ_LOW));

endmodule
`default_nettype wire

// ==== test/iec_src_model.sv ====
// Model of the peripheral event sources and the external request pins.
`timescale 1ns/100ps
`default_nettype none
module iec_src_model (
  // Clock.
  input  wire logic       clk,
  // Event pulses and pin levels.
  output logic            evt_timer_a,
  output logic            evt_serial1,
  output logic      [7:0] evt_high,
  output logic      [7:0] wakeup_evt,
  output logic      [4:0] ext_pin
);
  // Pins rest high, as with a pull-up, and events rest low.
  initial
  begin
    evt_timer_a = 1'b0;
    evt_serial1 = 1'b0;
    evt_high    = 8'h00;
    wakeup_evt  = 8'h00;
    ext_pin     = 5'h1f;
  end

  // Raises a set of events for exactly one clock cycle.
  task automatic pulse(input logic ta, input logic s1, input logic [7:0] hi, input logic [7:0] wk);
    @(posedge clk);
    evt_timer_a <= ta;
    evt_serial1 <= s1;
    evt_high    <= hi;
    wakeup_evt  <= wk;
    @(posedge clk);
    evt_timer_a <= 1'b0;
    evt_serial1 <= 1'b0;
    evt_high    <= 8'h00;
    wakeup_evt  <= 8'h00;
  endtask

  // Moves the pins and leaves the detector time to sample both levels.
  task automatic set_pins(input logic [4:0] v);
    @(posedge clk);
    ext_pin <= v;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== test/test_interrupt_enable_request_regs.sv ====
// Self-checking testbench of the interrupt control register block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(w, e, g) chk(w, 32'(e), 32'(g))
module test_interrupt_enable_request_regs;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        sys_clk  = 1'b0;
  logic        reset_n  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [17:0] paddr    = 18'h00000;
  logic [31:0] pwdata   = 32'h00000000;
  logic [4:0]  pin_mode = 5'h00;
  logic        cpu_mask = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ev_ta;
  logic        ev_s1;
  logic [7:0]  ev_hi;
  logic [7:0]  ev_wk;
  logic [4:0]  pins;
  logic [7:0]  req_low;
  logic [7:0]  req_high;
  logic        int_req;
  logic        irq_out;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  bit8;
  int          err_count   = 0;
  int          comparisons = 0;
  logic [15:0] idx_tab [6] = '{iec_pkg::IDX_EDGE_POLARITY_SELECT, iec_pkg::IDX_SOURCE_ENABLE_LOW,
                               iec_pkg::IDX_SOURCE_ENABLE_HIGH, iec_pkg::IDX_PENDING_FLAGS_LOW,
                               iec_pkg::IDX_PENDING_FLAGS_HIGH, iec_pkg::IDX_WAKEUP_PENDING_FLAGS};
  logic [7:0]  rst_tab [6] = '{8'he0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};

  // Clock of 40 ns period.
  always #20 sys_clk = ~sys_clk;

  // Design and event source model.
  iec_regs DUT (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_PIN(pins), .EXT_PIN_IRQ_MODE(pin_mode), .EVT_TIMER_A(ev_ta), .EVT_SERIAL1(ev_s1),
    .EVT_HIGH(ev_hi), .WAKEUP_EVT(ev_wk), .CPU_INT_MASK(cpu_mask), .REQ_LOW(req_low),
    .REQ_HIGH(req_high), .INT_REQ(int_req), .IRQ_OUT(irq_out)
  );
  iec_src_model src (
    .clk(sys_clk), .evt_timer_a(ev_ta), .evt_serial1(ev_s1), .evt_high(ev_hi), .wakeup_evt(ev_wk), .ext_pin(pins)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compares one value with four-state equality.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      give_verdict();
    end
  endtask

  // Writes one byte register.
  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    apb(1'b1, idx, {24'h000000, v});
  endtask

  // Reads one byte register and compares the whole word.
  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h00000000);
    `CHK(what, {24'h000000, exp}, rd);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset values of the register table.
    for (int i = 0; i < 6; i++)
      rd_chk("reset value", idx_tab[i], rst_tab[i]);
    // Reserved edge select bits read 1 whatever is written.
    wr(iec_pkg::IDX_EDGE_POLARITY_SELECT, 8'h00);
    rd_chk("edge sel 00", iec_pkg::IDX_EDGE_POLARITY_SELECT, 8'he0);
    wr(iec_pkg::IDX_EDGE_POLARITY_SELECT, 8'hff);
    rd_chk("edge sel ff", iec_pkg::IDX_EDGE_POLARITY_SELECT, 8'hff);
    wr(iec_pkg::IDX_EDGE_POLARITY_SELECT, 8'h00);
    wr(iec_pkg::IDX_SOURCE_ENABLE_LOW, 8'hff);
    rd_chk("en low", iec_pkg::IDX_SOURCE_ENABLE_LOW, 8'hff);
    wr(iec_pkg::IDX_SOURCE_ENABLE_HIGH, 8'haa);
    rd_chk("en high", iec_pkg::IDX_SOURCE_ENABLE_HIGH, 8'haa);
    // Each high source in turn: gating, sticky flag, write 1 keeps, write 0 clears.
    for (int i = 0; i < 8; i++)
    begin
      bit8 = 8'h01 << i;
      src.pulse(1'b0, 1'b0, bit8, 8'h00);
      @(negedge sys_clk);
      `CHK("req_high", bit8 & 8'haa, req_high);
      `CHK("int_req", |(bit8 & 8'haa), int_req);
      wr(iec_pkg::IDX_PENDING_FLAGS_HIGH, 8'hff);
      rd_chk("pend high kept", iec_pkg::IDX_PENDING_FLAGS_HIGH, bit8);
      wr(iec_pkg::IDX_PENDING_FLAGS_HIGH, ~bit8);
      rd_chk("pend high clr", iec_pkg::IDX_PENDING_FLAGS_HIGH, 8'h00);
    end
    // Timer A and serial 1 with only serial 1 enabled, then the CPU mask, then both enabled.
    wr(iec_pkg::IDX_SOURCE_ENABLE_LOW, 8'h40);
    src.pulse(1'b1, 1'b0, 8'h00, 8'h00);
    @(negedge sys_clk);
    `CHK("req_low ta", 8'h00, req_low);
    rd_chk("pend low ta", iec_pkg::IDX_PENDING_FLAGS_LOW, 8'ha0);
    src.pulse(1'b0, 1'b1, 8'h00, 8'h00);
    @(negedge sys_clk);
    `CHK("req_low s1", 8'h40, req_low);
    wr(iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h00);
    @(posedge sys_clk);
    cpu_mask <= 1'b1;
    src.pulse(1'b0, 1'b1, 8'h00, 8'h00);
    @(negedge sys_clk);
    `CHK("int_req masked", 1'b0, int_req);
    rd_chk("pend low masked", iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h60);
    @(posedge sys_clk);
    cpu_mask <= 1'b0;
    @(negedge sys_clk);
    `CHK("int_req unmasked", 1'b1, int_req);
    wr(iec_pkg::IDX_SOURCE_ENABLE_LOW, 8'hc0);
    src.pulse(1'b1, 1'b0, 8'h00, 8'h00);
    @(negedge sys_clk);
    `CHK("req_low ta on", 8'hc0, req_low);
    wr(iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h00);
    rd_chk("pend low clr", iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h20);
    // Wakeup group with one shared enable.
    wr(iec_pkg::IDX_SOURCE_ENABLE_LOW, 8'h00);
    src.pulse(1'b0, 1'b0, 8'h00, 8'h81);
    rd_chk("wakeup flags", iec_pkg::IDX_WAKEUP_PENDING_FLAGS, 8'h81);
    `CHK("req_low wk off", 8'h00, req_low);
    wr(iec_pkg::IDX_SOURCE_ENABLE_LOW, 8'h20);
    @(negedge sys_clk);
    `CHK("req_low wk on", 8'h20, req_low);
    wr(iec_pkg::IDX_WAKEUP_PENDING_FLAGS, 8'h7f);
    rd_chk("wakeup part clr", iec_pkg::IDX_WAKEUP_PENDING_FLAGS, 8'h01);
    wr(iec_pkg::IDX_WAKEUP_PENDING_FLAGS, 8'h00);
    // Pins: pin 0 not in request mode, falling then rising sensing.
    @(posedge sys_clk);
    pin_mode <= 5'h1e;
    wr(iec_pkg::IDX_SOURCE_ENABLE_LOW, 8'h1f);
    src.set_pins(5'h00);
    rd_chk("pins fall", iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h3e);
    `CHK("req_low pins", 8'h1e, req_low);
    wr(iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h00);
    src.set_pins(5'h1f);
    rd_chk("pins rise ign", iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h20);
    wr(iec_pkg::IDX_EDGE_POLARITY_SELECT, 8'h1f);
    src.set_pins(5'h00);
    rd_chk("pins fall ign", iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h20);
    src.set_pins(5'h1f);
    rd_chk("pins rise", iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h3e);
    // Block interrupt: status, enable and clear.
    wr(iec_pkg::IDX_PENDING_FLAGS_LOW, 8'h00);
    wr(iec_pkg::IDX_IRQ_CLEAR, 8'h07);
    rd_chk("status clr", iec_pkg::IDX_IRQ_STATUS, 8'h00);
    src.pulse(1'b0, 1'b0, 8'h01, 8'h00);
    rd_chk("status periph", iec_pkg::IDX_IRQ_STATUS, 8'h02);
    `CHK("irq_out off", 1'b0, irq_out);
    wr(iec_pkg::IDX_IRQ_ENABLE, 8'h02);
    @(negedge sys_clk);
    `CHK("irq_out on", 1'b1, irq_out);
    wr(iec_pkg::IDX_PENDING_FLAGS_HIGH, 8'h00);
    wr(iec_pkg::IDX_IRQ_CLEAR, 8'h02);
    rd_chk("status after clr", iec_pkg::IDX_IRQ_STATUS, 8'h00);
    `CHK("irq_out cleared", 1'b0, irq_out);
    // Unmapped address answers zero with an error.
    apb(1'b0, 16'h0000, 32'h00000000);
    `CHK("unmapped data", 32'h00000000, rd);
    `CHK("unmapped err", 1'b1, err);
    give_verdict();
  end
endmodule
`default_nettype wire
